// >>> core/led_buck_pkg.sv
// shared constants and carrier types for the switch-timing control
package led_buck_pkg;

  // clock rate in kHz (200 MHz)
  localparam int unsigned CLK_KHZ = 200000;

  // documented times in their own units
  localparam int unsigned BLANK_NS      = 120;
  localparam int unsigned BOOT_IDLE_MS  = 3;
  localparam int unsigned PULLDOWN_NS   = 1000;
  localparam int unsigned MAX_ON_NS     = 12000;
  localparam int unsigned PERIOD_NS     = 13000;

  // cycle counts: least times round up, longest times round down
  localparam int unsigned BLANK_CYC    = (BLANK_NS * (CLK_KHZ / 1000) + 999) / 1000;
  localparam int unsigned PULLDOWN_CYC = (PULLDOWN_NS * (CLK_KHZ / 1000)) / 1000;
  localparam int unsigned MAX_ON_CYC   = (MAX_ON_NS * (CLK_KHZ / 1000)) / 1000;
  localparam int unsigned BOOT_IDLE_CYC = BOOT_IDLE_MS * CLK_KHZ;
  // min off interval chosen so that on plus off fills the low-dropout period
  localparam int unsigned MIN_OFF_CYC  =
    ((PERIOD_NS - MAX_ON_NS) * (CLK_KHZ / 1000)) / 1000;

  // overcurrent skip counter saturation
  localparam int unsigned SKIP_MAX = 7;

  // reset values
  localparam logic [2:0] SKIP_RST = 3'h0;

  // synchronised comparator flags
  typedef struct packed {
    logic over_current;   // sensed current above peak limit
    logic neg_current;    // negative current limit reached
    logic skip_level;     // inductor current reached skip level
    logic comp_bottom;    // compensation node at or below bottom level
    logic temp_hot;       // junction at shutdown level
    logic temp_cool;      // junction back at restart level
  } comp_flags_t;

  // gate driver commands
  typedef struct packed {
    logic high_side_switch;
    logic low_side_pulldown;
  } gate_cmd_t;

endpackage : led_buck_pkg

// >>> core/led_buck_switch_control.sv
// switch-timing control for a step-down led driver
`timescale 1ns/1ps
// How it works
// - ignore overcurrent comparator for about 120 ns after each turn-on
// - peak current limit during conduction ends the on-time for this cycle
// - overcurrent at blanking end: turn off, skip count grows each repeat
// - skip count saturates at seven skipped pulses
// - no overcurrent at blanking end decrements skip count, floor zero
// - sustained overcurrent drops frequency to one eighth by skipping
// - light load: stay off until compensation node reaches bottom level
// - light load: stay on until inductor current reaches skip level
// - switch off over 3 ms enables small pull-down for boot recharge
// - every turn-off except at max on-time or over-temperature is followed by a minimum off interval
// - loop may demand up to 100% duty near dropout
// - max on-time forces switch off and pull-down on
// - forced pull-down ends on negative current or 1 us timeout
// - max on plus forced off gives 12 us within 13 us
// - over-temperature turns switch off and shuts down
// - restart after cooling with fresh soft-start
// - dimming input low inhibits switching
module led_buck_switch_control #(
  parameter int unsigned BOOT_IDLE_CYCLES = led_buck_pkg::BOOT_IDLE_CYC,
  parameter int unsigned SKIP_W           = 3
) (
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_rst,
  input  wire logic                      i_clk_en_sw,
  input  wire logic                      i_pwm_demand,
  input  wire logic                      i_light_load,
  input  wire logic                      i_dimming_input,
  input  wire led_buck_pkg::comp_flags_t i_comp,
  output logic                           o_high_side_switch,
  output logic                           o_low_side_pulldown,
  output logic                           o_soft_start_req,
  output logic [SKIP_W-1:0]              o_skip_count,
  output logic                           o_thermal_shutdown
);

  // elaboration check: counter must hold the saturation value
  if (SKIP_W < 3 || BOOT_IDLE_CYCLES < 2) begin : g_bad_param
    $error("unsupported parameter values");
  end

  // switch sequence states
  typedef enum logic [2:0] {
    ST_OFF, ST_BLANK, ST_ON, ST_FORCED_PD, ST_MIN_OFF, ST_SHUTDOWN
  } state_t;

  // timer width, wide enough for the boot idle count
  localparam int unsigned CW = 32;

  // synchroniser stages for comparator flags and dimming pin
  led_buck_pkg::comp_flags_t sync1_q, sync2_q;
  logic                      dim1_q, dim2_q;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      dim1_q  <= 1'b0;
      dim2_q  <= 1'b0;
    end
    else
    begin
      sync1_q <= i_comp;
      sync2_q <= sync1_q;
      dim1_q  <= i_dimming_input;
      dim2_q  <= dim1_q;
    end
  end

  // sequence state, phase timer, idle timer and skip counters
  state_t               state_q, state_d;
  logic [CW-1:0]        tmr_q, tmr_d;
  logic [CW-1:0]        idle_q, idle_d;
  logic [SKIP_W-1:0]    skip_q, skip_d;
  logic [SKIP_W-1:0]    skip_left_q, skip_left_d;
  logic                 ss_q, ss_d;
  logic                 pd_boot_q, pd_boot_d;

  // decrement with floor
  function automatic logic [SKIP_W-1:0] dec_sat(input logic [SKIP_W-1:0] v);
    dec_sat = (v == '0) ? v : v - 1'b1;
  endfunction : dec_sat

  // next-state logic for the switch sequence
  always_comb
  begin
    state_d     = state_q;
    tmr_d       = tmr_q;
    skip_d      = skip_q;
    skip_left_d = skip_left_q;
    ss_d        = 1'b0;
    case (state_q)
      ST_OFF:
      begin
        if (!dim2_q)
          state_d = ST_OFF;
        // each period enable eats one pending skip
        else if (i_clk_en_sw && skip_left_q != '0)
          skip_left_d = skip_left_q - 1'b1;
        // light load waits for compensation bottom
        else if (i_light_load ? sync2_q.comp_bottom : (i_clk_en_sw && i_pwm_demand))
        begin
          state_d = ST_BLANK;
          tmr_d   = '0;
        end
      end
      ST_BLANK:
      begin
        tmr_d = tmr_q + 1'b1;
        if (tmr_q + 1 >= led_buck_pkg::BLANK_CYC)
        begin
          if (sync2_q.over_current)
          begin
            if (skip_q < SKIP_W'(led_buck_pkg::SKIP_MAX))
              skip_d = skip_q + 1'b1;
            skip_left_d = (skip_q < SKIP_W'(led_buck_pkg::SKIP_MAX)) ?
                          skip_q + 1'b1 : skip_q;
            state_d = ST_MIN_OFF;
            tmr_d   = '0;
          end
          else
          begin
            // clean blanking end lowers skip count
            skip_d  = dec_sat(skip_q);
            state_d = ST_ON;
          end
        end
      end
      ST_ON:
      begin
        tmr_d = tmr_q + 1'b1;
        if (tmr_q + 1 >= led_buck_pkg::MAX_ON_CYC)
        begin
          state_d = ST_FORCED_PD;
          tmr_d   = '0;
        end
        // peak limit ends conduction this cycle
        else if (sync2_q.over_current || !dim2_q)
        begin
          state_d = ST_MIN_OFF;
          tmr_d   = '0;
        end
        // light load ends at skip level; else demand up to 100%
        else if (i_light_load ? sync2_q.skip_level : !i_pwm_demand)
        begin
          state_d = ST_MIN_OFF;
          tmr_d   = '0;
        end
      end
      ST_FORCED_PD:
      begin
        tmr_d = tmr_q + 1'b1;
        // end on negative current or timeout
        if (sync2_q.neg_current || tmr_q + 1 >= led_buck_pkg::PULLDOWN_CYC)
        begin
          state_d = ST_OFF;
          tmr_d   = '0;
        end
      end
      ST_MIN_OFF:
      begin
        tmr_d = tmr_q + 1'b1;
        if (tmr_q + 1 >= led_buck_pkg::MIN_OFF_CYC)
          state_d = ST_OFF;
      end
      ST_SHUTDOWN:
      begin
        // wait for cool flag, then fresh soft-start
        if (sync2_q.temp_cool && !sync2_q.temp_hot)
        begin
          state_d     = ST_OFF;
          ss_d        = 1'b1;
          skip_d      = led_buck_pkg::SKIP_RST;
          skip_left_d = led_buck_pkg::SKIP_RST;
        end
      end
      default:
        state_d = ST_OFF;
    endcase
    if (sync2_q.temp_hot)
    begin
      state_d = ST_SHUTDOWN;
      tmr_d   = '0;
    end
  end

  // boot idle timer: counts while the switch stays off, held at zero in shutdown
  always_comb
  begin
    idle_d    = idle_q;
    pd_boot_d = 1'b0;
    if (state_q == ST_BLANK || state_q == ST_ON || state_q == ST_SHUTDOWN)
      idle_d = '0;
    else if (idle_q < BOOT_IDLE_CYCLES)
      idle_d = idle_q + 1'b1;
    // long off time enables boot-recharge pull-down
    // drops in the same cycle the switch turns on: no shoot-through
    else
      pd_boot_d = (state_d == ST_OFF);
  end

  // state registers
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      state_q     <= ST_OFF;
      tmr_q       <= '0;
      idle_q      <= '0;
      skip_q      <= led_buck_pkg::SKIP_RST;
      skip_left_q <= led_buck_pkg::SKIP_RST;
      ss_q        <= 1'b0;
      pd_boot_q   <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      tmr_q       <= tmr_d;
      idle_q      <= idle_d;
      skip_q      <= skip_d;
      skip_left_q <= skip_left_d;
      ss_q        <= ss_d;
      pd_boot_q   <= pd_boot_d;
    end
  end

  // gate outputs decoded from the state and the boot pull-down register
  assign o_high_side_switch  = (state_q == ST_BLANK) || (state_q == ST_ON);
  assign o_low_side_pulldown = (state_q == ST_FORCED_PD) || pd_boot_q;
  assign o_soft_start_req    = ss_q;
  assign o_skip_count        = skip_q;
  assign o_thermal_shutdown  = (state_q == ST_SHUTDOWN);

  // assertions next to the guarded logic
  sequence s_turn_on;
    !o_high_side_switch ##1 o_high_side_switch;
  endsequence

  a_blank_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_turn_on |-> o_high_side_switch [*8])
    else $error("switch dropped during blanking");

  a_skip_sat: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    skip_q <= SKIP_W'(led_buck_pkg::SKIP_MAX))
    else $error("skip count above seven");

  a_skip_grow: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_q == ST_BLANK && state_d == ST_MIN_OFF && skip_q < SKIP_W'(7))
      |=> skip_q == $past(skip_q) + 1'b1)
    else $error("skip count did not grow");

  a_skip_drop: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_q == ST_BLANK && state_d == ST_ON) |=> skip_q == dec_sat($past(skip_q)))
    else $error("skip count did not drop");

  a_min_off: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $fell(o_high_side_switch) && !o_low_side_pulldown && !sync2_q.temp_hot
      |-> !o_high_side_switch [*8])
    else $error("off interval too short");

  a_pd_end: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(state_q == ST_FORCED_PD) |-> ##[1:210] state_q != ST_FORCED_PD)
    else $error("forced pull-down too long");

  a_max_on: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_q == ST_ON && tmr_q + 1 >= led_buck_pkg::MAX_ON_CYC && !sync2_q.temp_hot)
      |=> !o_high_side_switch && o_low_side_pulldown)
    else $error("max on-time not enforced");

  a_thermal_off: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    sync2_q.temp_hot |=> !o_high_side_switch && o_thermal_shutdown)
    else $error("switch on while hot");

  a_dim_inhibit: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (!dim2_q && state_q == ST_OFF) |=> !o_high_side_switch)
    else $error("turn-on while dimmed");

  a_no_overlap: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !(o_high_side_switch && o_low_side_pulldown))
    else $error("switch and pull-down on together");

  // conduction that meets the peak limit
  sequence s_peak_hit;
    state_q == ST_ON && sync2_q.over_current;
  endsequence

  a_peak_off: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_peak_hit |=> !o_high_side_switch)
    else $error("switch stayed on past peak limit");

  a_light_wait: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_q == ST_OFF && i_light_load && !sync2_q.comp_bottom) |=> !o_high_side_switch)
    else $error("turn-on above compensation bottom");

  a_light_end: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_q == ST_ON && i_light_load && sync2_q.skip_level) |=> !o_high_side_switch)
    else $error("light-load pulse passed skip level");

  a_boot_idle: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    pd_boot_q |-> (state_q == ST_OFF && idle_q >= BOOT_IDLE_CYCLES))
    else $error("boot pull-down outside long idle");

  // period enable while a skip is still pending
  sequence s_skip_pending;
    state_q == ST_OFF && i_clk_en_sw && skip_left_q != '0 && dim2_q && !sync2_q.temp_hot;
  endsequence

  a_skip_wait: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_skip_pending
      |=> !o_high_side_switch && skip_left_q == $past(skip_left_q) - 1'b1)
    else $error("skipped pulse not consumed");

  // cooling seen while shut down
  sequence s_cool_exit;
    state_q == ST_SHUTDOWN && sync2_q.temp_cool && !sync2_q.temp_hot;
  endsequence

  a_restart_ss: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_cool_exit |=> o_soft_start_req && !o_thermal_shutdown && o_skip_count == '0)
    else $error("restart without soft-start");

  a_ss_pulse: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_soft_start_req |=> !o_soft_start_req)
    else $error("soft-start request longer than one cycle");

endmodule : led_buck_switch_control

// >>> tb/led_buck_far_side.sv
// behavioural power stage driving the comparator flags
`timescale 1ns/1ps
module led_buck_far_side #(
  parameter int LIMIT    = 100,
  parameter int SKIP_LVL = 60,
  parameter int NEG_DLY  = 20
) (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_hs,
  input  wire logic                 i_pd,
  input  wire logic                 peak_current_limit_en,
  input  wire logic                 i_oc_force,
  input  wire logic                 i_neg_en,
  input  wire logic                 i_bottom,
  input  wire logic                 i_hot,
  output led_buck_pkg::comp_flags_t o_comp
);
  int cur    = 0;
  int pd_cnt = 0;
  // inductor charges while conducting, decays to zero otherwise
  always @(posedge i_clk_sys)
  begin
    if (i_hs) cur <= cur + 1;
    else if (cur > 0) cur <= cur - 1;
    pd_cnt <= i_pd ? pd_cnt + 1 : 0;
  end
  // flags as the analog comparators raise them
  always_comb
  begin
    o_comp.over_current = i_oc_force | (peak_current_limit_en & (cur >= LIMIT));
    o_comp.neg_current  = i_neg_en & (pd_cnt >= NEG_DLY);
    o_comp.skip_level   = cur >= SKIP_LVL;
    o_comp.comp_bottom  = i_bottom;
    o_comp.temp_hot     = i_hot;
    o_comp.temp_cool    = ~i_hot;
  end
endmodule : led_buck_far_side

// >>> tb/test_led_buck_switch_control.sv
// self-checking bench for the switch-timing control
`timescale 1ns/1ps
module test_led_buck_switch_control;
  localparam int BOOT = 1000;
  logic i_clk_sys;
  logic i_rst = 1, i_clk_en_sw = 0, i_pwm_demand = 0, i_light_load = 0, i_dimming_input = 1;
  logic lim_en = 0, oc_force = 0, neg_en = 0, bottom = 0, hot = 0, hs, pd, ss, sd;
  logic [2:0] skip;
  led_buck_pkg::comp_flags_t comp;
  logic [13:0] exp_q[$];
  int num_errors = 0, n_tests = 0, seed = 74649, n, w, w1;
  wire [6:0] obs = {hs, pd, ss, sd, skip};
  led_buck_switch_control #(.BOOT_IDLE_CYCLES(BOOT)) dut_u (.i_clk_sys(i_clk_sys),
    .i_rst(i_rst), .i_clk_en_sw(i_clk_en_sw), .i_pwm_demand(i_pwm_demand),
    .i_light_load(i_light_load), .i_dimming_input(i_dimming_input), .i_comp(comp),
    .o_high_side_switch(hs), .o_low_side_pulldown(pd), .o_soft_start_req(ss),
    .o_skip_count(skip), .o_thermal_shutdown(sd));
  led_buck_far_side far_u (.i_clk_sys(i_clk_sys), .i_hs(hs), .i_pd(pd), .peak_current_limit_en(lim_en),
    .i_oc_force(oc_force), .i_neg_en(neg_en), .i_bottom(bottom), .i_hot(hot), .o_comp(comp));
  // clock and watchdog
  initial
  begin
    i_clk_sys = 0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  initial
  begin
    #300000;
    num_errors++;
    report_and_stop();
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    n_tests++;
    if (seen !== expv)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expv);
    end
  endtask : check
  task automatic tick(input int k);
    repeat (k) @(posedge i_clk_sys);
    #1;
  endtask : tick
  task automatic note(input logic [6:0] m, input logic [6:0] v);
    exp_q.push_back({m, v});
  endtask : note
  // pulse the period enable until the switch turns on
  task automatic fire(output int r);
    r = 0;
    while (r < 20)
    begin
      i_clk_en_sw = 1;
      tick(1);
      i_clk_en_sw = 0;
      if (hs === 1'b1) break;
      r++;
      tick(4 + ($random(seed) & 3));
    end
  endtask : fire
  task automatic span(input int b, input logic lvl, output int c);
    c = 0;
    while (obs[b] === lvl && c < 3000)
    begin
      tick(1);
      c++;
    end
  endtask : span
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // monitor: every queued note against the outputs, oldest first, mid-cycle once settled
  always @(negedge i_clk_sys)
    while (exp_q.size() > 0)
    begin
      check(obs & exp_q[0][13:7], exp_q[0][6:0]);
      void'(exp_q.pop_front());
    end
  // main sequence
  initial
  begin
    tick(5);
    note(7'h7f, 7'h00);
    i_rst = 0;
    tick(5);
    i_pwm_demand = 1;
    lim_en = 1;
    fire(n);
    note(7'h40, 7'h40);
    span(6, 1, w);
    check(w inside {[100:106]}, 1);
    lim_en = 0;
    tick(100);
    i_clk_en_sw = 1;
    tick(1);
    i_clk_en_sw = 0;
    note(7'h40, 7'h00);
    tick(110);
    fire(n);
    check(n, 0);
    tick(30 + ($random(seed) & 15));
    i_pwm_demand = 0;
    span(6, 1, w);
    check(w, 1);
    tick(300);
    i_light_load = 1;
    fire(n);
    check(n, 20);
    bottom = 1;
    span(6, 0, w);
    check(w <= 6, 1);
    bottom = 0;
    span(6, 1, w);
    check(w inside {[60:66]}, 1);
    i_light_load = 0;
    i_pwm_demand = 1;
    oc_force = 1;
    for (int k = 1; k <= 9; k++)
    begin
      tick(210);
      fire(n);
      check(n, (k > 8) ? 7 : k - 1);
      span(6, 1, w);
      check(w inside {[24:26]}, 1);
      note(7'h07, 7'((k > 7) ? 7 : k));
    end
    oc_force = 0;
    tick(210);
    fire(n);
    check(n, 7);
    tick(40);
    note(7'h47, 7'h46);
    // end this pulse so each max-on run below starts from a fresh turn-on
    i_pwm_demand = 0;
    tick(1);
    i_pwm_demand = 1;
    note(7'h40, 7'h00);
    for (int j = 0; j < 2; j++)
    begin
      neg_en = j;
      tick(210);
      fire(n);
      span(6, 1, w);
      check(w, 2400);
      note(7'h60, 7'h20);
      span(5, 1, w);
      check(j ? (w inside {[20:26]}) : (w == 200), 1);
    end
    span(5, 0, w1);
    check((w + w1) inside {[BOOT:BOOT+240]}, 1);
    i_dimming_input = 0;
    tick(4);
    fire(n);
    check(n, 20);
    i_dimming_input = 1;
    tick(4);
    fire(n);
    note(7'h60, 7'h40);
    tick(30);
    hot = 1;
    span(6, 1, w);
    check(w inside {[2:5]}, 1);
    note(7'h48, 7'h08);
    tick(20);
    fire(n);
    check(n, 20);
    hot = 0;
    span(4, 0, w);
    check(w <= 6, 1);
    note(7'h1f, 7'h10);
    tick(1);
    note(7'h10, 7'h00);
    tick(2);
    report_and_stop();
  end
endmodule : test_led_buck_switch_control
